/* rtl/ques_status_pkg.sv */
package ques_status_pkg;
    localparam int REG_W = 16;
    // Register selector codes on the command port
    localparam logic [2:0] SEL_COND = 3'h0;
    localparam logic [2:0] SEL_PTR = 3'h1;
    localparam logic [2:0] SEL_NTR = 3'h2;
    localparam logic [2:0] SEL_EVENT = 3'h3;
    localparam logic [2:0] SEL_ENABLE = 3'h4;
    // Condition bit positions
    localparam int BIT_POWER = 3;
    localparam int BIT_OVEN = 4;
    localparam int BIT_FREQ = 5;
    localparam int BIT_MOD = 7;
    localparam int BIT_CAL = 8;
    localparam int BIT_SELFTEST = 9;
    // Reset values
    localparam logic [15:0] PTR_RST = 16'hffff;
    localparam logic [15:0] NTR_RST = 16'h0000;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;
endpackage

/* rtl/questionable_status_group.sv */
// Operation
// - Condition bits 0, 1, 2 and 10 to 14 always read zero.
// - Condition bits 6 and 15 always read zero.
// - Bit 3 is power summary: unleveled loop or reverse power tripped.
// - Bit 4 is high while the reference oven is cold.
// - Bit 5 is the frequency unlock summary.
// - Bit 7 is the modulation range summary.
// - Bit 8 is the calibration summary, dc coupled fm/pm zero cal failed.
// - Bit 9 sets on self-test failure, cleared only by power cycle.
// - Clear-status leaves the self-test bit unchanged.
// - Condition query returns the weighted sum of set bits.
// - Positive filter passes 0-to-1 changes, negative filter 1-to-0 changes.
// - Host writes filters as bit sums; device stores and returns them.
// - Event register latches and holds each passed transition.
// - Event read returns contents then clears all bits except those with a new transition in the read cycle.
// - Summary bit 3 of status byte high when any enabled event set.
// - Enable query returns the last written enable mask.
// - Several enable bits combine by logical OR.
// - Condition register tracks hardware; writes to it do nothing.
`timescale 1ns/10ps
module questionable_status_group
    import ques_status_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic unleveled_i,
    input wire logic reverse_power_trip_i,
    input wire logic oven_cold_i,
    input wire logic freq_unlock_i,
    input wire logic mod_fault_i,
    input wire logic dc_coupled_fm_pm_cal_fail_i,
    input wire logic selftest_fail_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [2:0] sel_i,
    input wire logic [REG_W-1:0] wdata_i,
    input wire logic clear_status_i,
    output logic [REG_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic [REG_W-1:0] cond_o,
    output logic summary_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // One selector compare shared by every read and write decode
    function automatic logic sel_match(input logic [2:0] sel, input logic [2:0] code);
        return sel == code;
    endfunction

    // Bits that went from low to high between two condition samples
    function automatic logic [REG_W-1:0] rise_of(input logic [REG_W-1:0] prev, input logic [REG_W-1:0] curr);
        return ~prev & curr;
    endfunction

    // Bits that went from high to low between two condition samples
    function automatic logic [REG_W-1:0] fall_of(input logic [REG_W-1:0] prev, input logic [REG_W-1:0] curr);
        return prev & ~curr;
    endfunction

    // Any event that the mask lets through raises the summary
    function automatic logic summary_of(input logic [REG_W-1:0] events, input logic [REG_W-1:0] mask);
        return |(events & mask);
    endfunction

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Release is synchronised so every flop but selftest_r and the two synchroniser flops leaves reset on the same edge
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ----------------------------------------
    // Condition sources
    // ----------------------------------------
    // Sub-group detail stays outside except power's two faults; the other groups arrive as summaries
    logic power_flag;
    logic oven_flag;
    logic freq_flag;
    logic mod_flag;
    logic cal_flag;

    // Either power fault alone is enough to mark the output questionable
    assign power_flag = unleveled_i | reverse_power_trip_i;
    assign oven_flag = oven_cold_i;
    assign freq_flag = freq_unlock_i;
    assign mod_flag = mod_fault_i;
    assign cal_flag = dc_coupled_fm_pm_cal_fail_i;

    // ----------------------------------------
    // Self-test capture
    // ----------------------------------------
    // Self-test failure is sticky; only the power-on reset clears it
    logic selftest_r;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            selftest_r <= 1'b0;
        end else if (selftest_fail_i) begin
            selftest_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Condition register
    // ----------------------------------------
    // Unused positions start at zero and nothing ever sets them
    logic [REG_W-1:0] cond_nxt;
    always_comb begin
        cond_nxt = ZERO16;
        cond_nxt[BIT_POWER] = power_flag;
        cond_nxt[BIT_OVEN] = oven_flag;
        cond_nxt[BIT_FREQ] = freq_flag;
        cond_nxt[BIT_MOD] = mod_flag;
        cond_nxt[BIT_CAL] = cal_flag;
        cond_nxt[BIT_SELFTEST] = selftest_r;
    end

    // No write path exists for the condition register
    logic [REG_W-1:0] cond_r;
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cond_r <= ZERO16;
        end else begin
            cond_r <= cond_nxt;
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Each register sees its own strobe so the read mux stays out of the write path
    logic wr_ptr;
    logic wr_ntr;
    logic wr_enable;
    logic rd_event;

    assign wr_ptr = wr_i && sel_match(sel_i, SEL_PTR);
    assign wr_ntr = wr_i && sel_match(sel_i, SEL_NTR);
    assign wr_enable = wr_i && sel_match(sel_i, SEL_ENABLE);
    // Writes to the condition and event selectors decode to nothing on purpose
    assign rd_event = rd_i && sel_match(sel_i, SEL_EVENT);

    // ----------------------------------------
    // Filters and enable mask
    // ----------------------------------------
    // Positive filter resets open so rising faults are caught from the start
    logic [REG_W-1:0] ptr_r;
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ptr_r <= PTR_RST;
        end else if (wr_ptr) begin
            ptr_r <= wdata_i;
        end
    end

    // Negative filter resets closed; clearing faults are ignored until asked for
    logic [REG_W-1:0] ntr_r;
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ntr_r <= NTR_RST;
        end else if (wr_ntr) begin
            ntr_r <= wdata_i;
        end
    end

    // Mask resets closed so the summary stays quiet until the host opts in
    logic [REG_W-1:0] enable_r;
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            enable_r <= ENABLE_RST;
        end else if (wr_enable) begin
            enable_r <= wdata_i;
        end
    end

    // ----------------------------------------
    // Transition capture
    // ----------------------------------------
    logic [REG_W-1:0] cond_rise;
    logic [REG_W-1:0] cond_fall;
    logic [REG_W-1:0] hit;

    // Edges are taken against the next sample so events land with cond_o
    assign cond_rise = rise_of(cond_r, cond_nxt);
    assign cond_fall = fall_of(cond_r, cond_nxt);
    assign hit = (ptr_r & cond_rise) | (ntr_r & cond_fall);

    // ----------------------------------------
    // Event register
    // ----------------------------------------
    logic [REG_W-1:0] event_r;
    logic [REG_W-1:0] event_nxt;
    logic event_clr;

    // A destructive read and the clear-status command share one clear path
    assign event_clr = rd_event || clear_status_i;

    always_comb begin
        event_nxt = event_r | hit;
        if (event_clr) begin
            // New transitions win over the clear so none is lost
            event_nxt = hit;
        end
    end

    // Event bits change only here
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            event_r <= ZERO16;
        end else begin
            event_r <= event_nxt;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // The answer always carries the value from before this cycle's update
    logic [REG_W-1:0] rdata_nxt;
    always_comb begin
        rdata_nxt = ZERO16;
        if (sel_match(sel_i, SEL_COND)) begin
            rdata_nxt = cond_r;
        end else if (sel_match(sel_i, SEL_PTR)) begin
            rdata_nxt = ptr_r;
        end else if (sel_match(sel_i, SEL_NTR)) begin
            rdata_nxt = ntr_r;
        end else if (sel_match(sel_i, SEL_EVENT)) begin
            rdata_nxt = event_r;
        end else if (sel_match(sel_i, SEL_ENABLE)) begin
            rdata_nxt = enable_r;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Valid is a single pulse one cycle after the request
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
        end
    end

    // Read data holds until the next read so a slow host can pick it up late
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_o <= ZERO16;
        end else if (rd_i) begin
            rdata_o <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Status summary
    // ----------------------------------------
    // Summary uses next-state events so it rises on the same edge as the event bit
    logic summary_nxt;
    assign summary_nxt = summary_of(event_nxt, enable_r);

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Live condition leaves on the same edge as the copy that queries see
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cond_o <= ZERO16;
        end else begin
            cond_o <= cond_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            summary_o <= 1'b0;
        end else begin
            summary_o <= summary_nxt;
        end
    end

endmodule

/* testbench/ques_host_model.sv */
`timescale 1ns/10ps
module ques_host_model
    import ques_status_pkg::*;
(
    input wire logic clock_i,
    input wire logic rvalid_i,
    input wire logic [REG_W-1:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic clr_o,
    output logic [2:0] sel_o,
    output logic [REG_W-1:0] wdata_o
);
    initial {wr_o, rd_o, clr_o, sel_o, wdata_o} = '0;
    // k is {write, read, clear}; data is scrambled once released, so stale values never pass
    task automatic cmd(input logic [2:0] k, s, input logic [REG_W-1:0] d, output logic [REG_W-1:0] q);
        @(negedge clock_i);
        {wr_o, rd_o, clr_o, sel_o, wdata_o} = {k, s, d};
        @(negedge clock_i);
        {wr_o, rd_o, clr_o, wdata_o} = {3'h0, ~d};
        q = rvalid_i ? rdata_i : 16'hxxxx;
    endtask
endmodule

/* testbench/ques_status_monitor.sv */
`timescale 1ns/10ps
module ques_status_monitor
    import ques_status_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic unleveled_i,
    input wire logic reverse_power_trip_i,
    input wire logic oven_cold_i,
    input wire logic freq_unlock_i,
    input wire logic mod_fault_i,
    input wire logic dc_coupled_fm_pm_cal_fail_i,
    input wire logic selftest_fail_i,
    input wire logic rd_i,
    input wire logic rvalid_o,
    input wire logic [REG_W-1:0] rdata_o,
    input wire logic [REG_W-1:0] cond_o
);
    logic [2:0] up_r;
    // Hold off until the reset synchroniser and first condition sample have settled
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) up_r <= 3'h0;
        else if (!up_r[2]) up_r <= up_r + 3'h1;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i || !up_r[2]);
    // Fail is captured on one edge and reaches cond_o on the next
    sequence s_fail_seen;
        selftest_fail_i;
    endsequence
    sequence s_bit9_up;
        ##2 cond_o[9];
    endsequence
    a_unused_low: assert property (cond_o[14:10] == 5'h00 && cond_o[2:0] == 3'h0) else $error("unused bit");
    a_top_low: assert property (!cond_o[15] && !cond_o[6]) else $error("bit 6 or 15");
    a_power_bit: assert property (cond_o[3] == ($past(unleveled_i) | $past(reverse_power_trip_i)))
        else $error("bit 3");
    a_oven_bit: assert property (cond_o[4] == $past(oven_cold_i)) else $error("bit 4");
    a_freq_bit: assert property (cond_o[5] == $past(freq_unlock_i)) else $error("bit 5");
    a_mod_bit: assert property (cond_o[7] == $past(mod_fault_i)) else $error("bit 7");
    a_cal_bit: assert property (cond_o[8] == $past(dc_coupled_fm_pm_cal_fail_i)) else $error("bit 8");
    a_selftest_set: assert property (s_fail_seen |-> s_bit9_up) else $error("bit 9 set");
    a_selftest_hold: assert property (cond_o[9] |=> cond_o[9]) else $error("bit 9 hold");
    a_read_answer: assert property (rvalid_o == $past(rd_i)) else $error("read answer");
    a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o)) else $error("read data moved");
endmodule
bind questionable_status_group ques_status_monitor u_mon (.*);

/* testbench/questionable_status_group_tb_top.sv */
`timescale 1ns/10ps
module questionable_status_group_tb_top;
    import ques_status_pkg::*;
    logic clock_i = '0, arst_n_i = '0, unleveled_i = '0, reverse_power_trip_i = '0, oven_cold_i = '0;
    logic freq_unlock_i = '0, mod_fault_i = '0, dc_coupled_fm_pm_cal_fail_i = '0, selftest_fail_i = '0;
    logic wr_i, rd_i, clear_status_i, rvalid_o, summary_o;
    logic [2:0] sel_i;
    logic [REG_W-1:0] wdata_i, rdata_o, cond_o, q;
    int failures = 0;
    int checks = 0;
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    questionable_status_group u_dut (.*);
    ques_host_model u_host (.clock_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i),
        .clr_o(clear_status_i), .sel_o(sel_i), .wdata_o(wdata_i));
    task automatic chk(input string n, input logic [REG_W-1:0] e, g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [2:0] s, input logic [REG_W-1:0] e);
        u_host.cmd(3'h2, s, ZERO16, q);
        chk("read", e, q);
    endtask
    task automatic schk(input logic e);
        chk("summary", {15'h0000, e}, {15'h0000, summary_o});
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        rchk(SEL_PTR, PTR_RST);
        u_host.cmd(3'h4, SEL_COND, 16'hffff, q);
        rchk(SEL_COND, ZERO16);
        u_host.cmd(3'h4, SEL_PTR, 16'h0338, q);
        u_host.cmd(3'h4, SEL_NTR, 16'h0010, q);
        u_host.cmd(3'h4, SEL_ENABLE, 16'h0208, q);
        rchk(SEL_PTR, 16'h0338);
        rchk(SEL_ENABLE, 16'h0208);
        {unleveled_i, oven_cold_i, freq_unlock_i, mod_fault_i, dc_coupled_fm_pm_cal_fail_i, selftest_fail_i} = 6'h3f;
        @(negedge clock_i);
        selftest_fail_i = 1'b0;
        repeat (3) @(negedge clock_i);
        schk(1'b1);
        rchk(SEL_COND, 16'h03b8);
        rchk(SEL_EVENT, 16'h0338);
        rchk(SEL_EVENT, ZERO16);
        schk(1'b0);
        {unleveled_i, oven_cold_i} = 2'h0;
        repeat (4) @(negedge clock_i);
        rchk(SEL_EVENT, 16'h0010);
        reverse_power_trip_i = 1'b1;
        repeat (4) @(negedge clock_i);
        schk(1'b1);
        u_host.cmd(3'h1, SEL_COND, ZERO16, q);
        rchk(SEL_EVENT, ZERO16);
        // The oven edge lands on the very edge that takes the event read
        fork
            rchk(SEL_EVENT, ZERO16);
            begin
                @(negedge clock_i);
                oven_cold_i = 1'b1;
            end
        join
        rchk(SEL_EVENT, 16'h0010);
        rchk(SEL_COND, 16'h03b8);
        print_verdict();
    end
    // The sequence needs well under 200 cycles; this margin only catches a hang
    initial begin
        #20000;
        failures++;
        print_verdict();
    end
endmodule
